/* File: logic/swlls_pkg.sv */
// Constants and types for the raw sector write and log selection engine
package swlls_pkg;
  localparam logic [7:0]  OP_WLONG     = 8'h3F;
  localparam logic [7:0]  OP_LSEL      = 8'h4C;
  localparam logic [15:0] WL_FULL      = 16'h020E;
  localparam logic [9:0]  WL_USER      = 10'h200;
  localparam logic [9:0]  WL_XCHK      = 10'h002;
  localparam logic [9:0]  WL_ECC       = 10'h00C;
  localparam logic [1:0]  SEC_USER     = 2'h0;
  localparam logic [1:0]  SEC_XCHK     = 2'h1;
  localparam logic [1:0]  SEC_ECC      = 2'h2;
  localparam logic [7:0]  ST_GOOD      = 8'h00;
  localparam logic [7:0]  ST_CHECK     = 8'h02;
  localparam logic [3:0]  SK_NONE      = 4'h0;
  localparam logic [3:0]  SK_ILLEGAL   = 4'h5;
  localparam logic [3:0]  SK_UNIT_ATTN = 4'h6;
  localparam logic [7:0]  ASC_NONE     = 8'h00;
  localparam logic [7:0]  ASC_BAD_OP   = 8'h20;
  localparam logic [7:0]  ASC_CDB      = 8'h24;
  localparam logic [7:0]  ASC_PLIST    = 8'h26;
  localparam logic [7:0]  ASC_LOGCHG   = 8'h2A;
  localparam logic [7:0]  ASCQ_LOGCHG  = 8'h02;
  localparam int          SP_BIT       = 0;
  localparam int          PCR_BIT      = 1;
  localparam int          DS_BIT       = 6;
  localparam logic [1:0]  PC_CUR_THR   = 2'h0;
  localparam logic [1:0]  PC_CUR_CUM   = 2'h1;
  localparam logic [1:0]  PC_DEF_THR   = 2'h2;
  localparam logic [1:0]  PC_DEF_CUM   = 2'h3;
  localparam logic [5:0]  PG_SUPP      = 6'h00;
  localparam logic [5:0]  PG_WERR      = 6'h02;
  localparam logic [5:0]  PG_RERR      = 6'h03;
  localparam logic [5:0]  PG_VERR      = 6'h05;
  localparam logic [5:0]  PG_NME       = 6'h06;
  localparam logic [5:0]  PG_POH       = 6'h08;
  localparam logic [15:0] PAR_ZERO     = 16'h0000;
  localparam logic [15:0] PAR_WMIN     = 16'h0001;
  localparam logic [15:0] PAR_MAX      = 16'h0006;
  localparam logic [7:0]  REG_CDB0     = 8'h00;
  localparam logic [7:0]  REG_CDB1     = 8'h04;
  localparam logic [7:0]  REG_CDB2     = 8'h08;
  localparam logic [7:0]  REG_CTRL     = 8'h0C;
  localparam logic [7:0]  REG_STAT     = 8'h10;
  localparam logic [7:0]  REG_SENSE    = 8'h14;
  localparam logic [7:0]  REG_INFO     = 8'h18;
  localparam logic [7:0]  REG_UA       = 8'h1C;
  localparam int          CTRL_START   = 0;
  localparam int          CTRL_SAVE    = 1;
  localparam int          CTRL_ID_LSB  = 4;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WL   = 4'b0010,
    S_LS   = 4'b0100,
    S_END  = 4'b1000
  } swlls_state_t;

  typedef enum logic [2:0] {
    F_PAGE = 3'b001,
    F_PARM = 3'b010,
    F_VAL  = 3'b100
  } swlls_fld_t;
endpackage

/* File: logic/swlls_param_check.sv */
// Supported log page and parameter code lookup
`timescale 1ns/1ps
`default_nettype none
module swlls_param_check
  import swlls_pkg::*;
(
  input  wire logic [5:0]  page,
  input  wire logic [15:0] code,
  output logic             pageOk,
  output logic             codeOk,
  output logic             thrOk
);
  always_comb
  begin
    pageOk = 1'b0;
    codeOk = 1'b0;
    thrOk  = 1'b0;
    case (page)
      PG_SUPP:
      begin
        pageOk = 1'b1;
      end
      PG_WERR:
      begin
        pageOk = 1'b1;
        codeOk = (code >= PAR_WMIN) && (code <= PAR_MAX);
        thrOk  = 1'b1;
      end
      PG_RERR, PG_VERR:
      begin
        pageOk = 1'b1;
        codeOk = code <= PAR_MAX;
        thrOk  = 1'b1;
      end
      PG_NME, PG_POH:
      begin
        pageOk = 1'b1;
        codeOk = code == PAR_ZERO;
      end
      default:
      begin
        pageOk = 1'b0;
      end
    endcase
  end
endmodule // swlls_param_check
`default_nettype wire

/* File: logic/swlls_engine.sv */
// Raw sector write and log parameter selection command engine
// Functional notes
// - Opcode 3Fh: LBA bytes 2-5, count 7-8
// - Sector is 512 data, 2 check, 12 ECC
// - Zero byte count moves no data
// - Illegal count: check, invalid CDB field
// - Info field holds count minus 526
// - Opcode 4Ch: SP, PCR, PC, list length
// - SP set: save savable parameters after operation
// - PCR with zero length resets all parameters
// - PCR with nonzero length: invalid CDB field
// - SP without any saving support: invalid CDB
// - DS set with SP is no error
// - PC selects current/default threshold/cumulative
// - PC 10b, zero length: default thresholds
// - PC 11b, zero length: default cumulatives
// - Unavailable threshold change: invalid list field
// - List length zero sends nothing, no error
// - Unknown page or parameter code rejected
// - Truncated parameter: invalid CDB field
// - Out of order codes rejected
// - Changes raise unit attention for others
// - Unsupported parameter: invalid list field
// - Pages 0,2,3,5,6,8 only
`timescale 1ns/1ps
`default_nettype none
module swlls_engine
  import swlls_pkg::*;
#(
  parameter int NUM_INIT = 8
)
(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [7:0]          regAddr,
  input  wire logic [31:0]         regWdata,
  input  wire logic                regWr,
  input  wire logic                regRd,
  output logic      [31:0]         regRdata,
  input  wire logic [7:0]          dataIn,
  input  wire logic                dataValid,
  output logic                     dataReady,
  output logic      [7:0]          medData,
  output logic                     medValid,
  output logic      [1:0]          medSec,
  output logic                     medLast,
  input  wire logic                medReady,
  output logic      [31:0]         medLba,
  output logic                     logReset,
  output logic                     thrDefault,
  output logic                     cumDefault,
  output logic                     saveReq,
  output logic                     paramWr,
  output logic      [5:0]          paramPage,
  output logic      [15:0]         paramCode,
  output logic      [31:0]         paramValue,
  output logic      [1:0]          paramKind,
  output logic                     paramSaved,
  output logic                     cmdDone,
  output logic      [NUM_INIT-1:0] uaPending
);
  localparam int IDW = $clog2(NUM_INIT);

  swlls_state_t          state_r;
  swlls_fld_t            fld_r;
  logic [31:0]           cdbW0_r, cdbW1_r;
  logic [15:0]           cdbW2_r;
  logic                  cfgSave_r;
  logic [IDW-1:0]        initId_r;
  logic [7:0]            opc_r;
  logic                  sp_r, pcr_r;
  logic [1:0]            pc_r;
  logic [15:0]           len_r;
  logic [7:0]            status_r;
  logic                  done_r, lsOk_r, changed_r;
  logic [3:0]            senseKey_r;
  logic [7:0]            asc_r;
  logic [31:0]           info_r;
  logic [9:0]            wlCnt_r;
  logic [1:0]            pos_r;
  logic [15:0]           remain_r, pageLeft_r, curCode_r, lastCode_r;
  logic [5:0]            curPage_r, lastPage_r;
  logic                  havePage_r, haveParm_r;
  logic [7:0]            ctl_r, valLeft_r;
  logic [31:0]           val_r;
  logic [NUM_INIT-1:0]   ua_r;
  logic [7:0]            cOpc;
  logic [15:0]           cLen, chkCode;
  logic                  startP, acc, pageOk, codeOk, thrOk;
  logic                  errPl, errCdb, parmEnd, hdrEnd, atLast;
  logic                  endReq, endChk;
  logic [7:0]            endAsc;
  logic [31:0]           endInfo;
  logic [NUM_INIT-1:0]   uaSet, uaClr;

  assign cOpc    = cdbW0_r[7:0];
  assign cLen    = {cdbW1_r[31:24], cdbW2_r[7:0]};
  assign startP  = ce && regWr && regAddr == REG_CTRL && regWdata[CTRL_START]
                   && state_r == S_IDLE;
  assign acc     = dataValid && dataReady;
  assign chkCode = {curCode_r[15:8], dataIn};
  assign atLast  = remain_r == 16'h0001;
  assign uaPending = ua_r;

  swlls_param_check u_check (
    .page   ((fld_r == F_PAGE) ? dataIn[5:0] : curPage_r),
    .code   (chkCode),
    .pageOk (pageOk),
    .codeOk (codeOk),
    .thrOk  (thrOk)
  );

  always_comb
  begin
    dataReady = 1'b0;
    case (state_r)
      S_WL:    dataReady = wlCnt_r != WL_FULL[9:0] && (!medValid || medReady);
      S_LS:    dataReady = 1'b1;
      default: dataReady = 1'b0;
    endcase
  end

  // Per-byte list checks
  always_comb
  begin
    errPl   = 1'b0;
    parmEnd = 1'b0;
    hdrEnd  = 1'b0;
    case (fld_r)
      F_PAGE:
      begin
        if (pos_r == 2'h0 && (!pageOk || (havePage_r && dataIn[5:0] <= lastPage_r)))
          errPl = 1'b1;
        hdrEnd = pos_r == 2'h3;
      end
      F_PARM:
      begin
        if (pos_r == 2'h1 && (!codeOk || (haveParm_r && chkCode <= lastCode_r)))
          errPl = 1'b1;
        if (pos_r == 2'h1 && pc_r == PC_CUR_THR && !thrOk)
          errPl = 1'b1;
        parmEnd = pos_r == 2'h3 && dataIn == 8'h00;
      end
      F_VAL:
      begin
        parmEnd = valLeft_r == 8'h01;
      end
      default:
      begin
        errPl = 1'b1;
      end
    endcase
    errCdb = atLast && !parmEnd
             && !(hdrEnd && {pageLeft_r[15:8], dataIn} == 16'h0000);
  end

  // Command decode and termination
  always_comb
  begin
    endReq  = 1'b0;
    endChk  = 1'b0;
    endAsc  = ASC_CDB;
    endInfo = 32'h0000_0000;
    case (state_r)
      S_IDLE:
      begin
        if (startP && cOpc == OP_WLONG)
        begin
          if (cLen != WL_FULL)
          begin
            endReq  = 1'b1;
            endChk  = cLen != 16'h0000;
            endInfo = endChk ? {16'h0000, cLen} - {16'h0000, WL_FULL} : 32'h0;
          end
        end
        else if (startP && cOpc == OP_LSEL)
        begin
          endChk = (cdbW0_r[8+PCR_BIT] && cLen != 16'h0000)
                   || (cdbW0_r[8+SP_BIT] && !regWdata[CTRL_SAVE]);
          endReq = endChk || cLen == 16'h0000;
        end
        else if (startP)
        begin
          endReq = 1'b1;
          endChk = 1'b1;
          endAsc = ASC_BAD_OP;
        end
      end
      S_WL:    endReq = wlCnt_r == WL_FULL[9:0] && !medValid;
      S_LS:
      begin
        endReq = acc && (errPl || errCdb || atLast);
        endChk = acc && (errPl || errCdb);
        endAsc = errPl ? ASC_PLIST : ASC_CDB;
      end
      default: endReq = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_r <= S_IDLE;
    else if (ce)
    begin
      case (state_r)
        S_IDLE:
        begin
          if (endReq)
            state_r <= S_END;
          else if (startP)
            state_r <= (cOpc == OP_WLONG) ? S_WL : S_LS;
        end
        S_WL, S_LS:
        begin
          if (endReq)
            state_r <= S_END;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Latched command fields
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      opc_r  <= 8'h00;
      sp_r   <= 1'b0;
      pcr_r  <= 1'b0;
      pc_r   <= PC_CUR_THR;
      len_r  <= 16'h0000;
      medLba <= 32'h0000_0000;
    end
    else if (ce && startP)
    begin
      opc_r  <= cOpc;
      sp_r   <= cdbW0_r[8+SP_BIT];
      pcr_r  <= cdbW0_r[8+PCR_BIT];
      pc_r   <= cdbW0_r[23:22];
      len_r  <= cLen;
      medLba <= {cdbW0_r[23:16], cdbW0_r[31:24], cdbW1_r[7:0], cdbW1_r[15:8]};
    end
  end

  // Completion status and sense hold
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_r   <= ST_GOOD;
      senseKey_r <= SK_NONE;
      asc_r      <= ASC_NONE;
      info_r     <= 32'h0000_0000;
      done_r     <= 1'b0;
      lsOk_r     <= 1'b0;
    end
    else if (ce)
    begin
      if (startP)
        done_r <= 1'b0;
      else if (state_r == S_END)
        done_r <= 1'b1;
      if (endReq)
      begin
        status_r <= endChk ? ST_CHECK : ST_GOOD;
        lsOk_r   <= !endChk && (state_r == S_LS || cOpc == OP_LSEL && state_r == S_IDLE);
        if (endChk)
        begin
          senseKey_r <= SK_ILLEGAL;
          asc_r      <= endAsc;
          info_r     <= endInfo;
        end
      end
    end
  end

  // Raw sector stream to the medium
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wlCnt_r  <= 10'h000;
      medValid <= 1'b0;
      medData  <= 8'h00;
      medSec   <= SEC_USER;
      medLast  <= 1'b0;
    end
    else if (ce)
    begin
      if (startP)
        wlCnt_r <= 10'h000;
      if (state_r == S_WL && acc)
      begin
        wlCnt_r  <= wlCnt_r + 10'h001;
        medValid <= 1'b1;
        medData  <= dataIn;
        medSec   <= (wlCnt_r < WL_USER) ? SEC_USER :
                    (wlCnt_r < WL_USER + WL_XCHK) ? SEC_XCHK : SEC_ECC;
        medLast  <= wlCnt_r == WL_USER + WL_XCHK + WL_ECC - 10'h001;
      end
      else if (medReady)
        medValid <= 1'b0;
    end
  end

  // Parameter list parser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fld_r      <= F_PAGE;
      pos_r      <= 2'h0;
      remain_r   <= 16'h0000;
      pageLeft_r <= 16'h0000;
      curPage_r  <= 6'h00;
      lastPage_r <= 6'h00;
      curCode_r  <= 16'h0000;
      lastCode_r <= 16'h0000;
      havePage_r <= 1'b0;
      haveParm_r <= 1'b0;
      ctl_r      <= 8'h00;
      valLeft_r  <= 8'h00;
      val_r      <= 32'h0000_0000;
      changed_r  <= 1'b0;
    end
    else if (ce && startP)
    begin
      fld_r      <= F_PAGE;
      pos_r      <= 2'h0;
      remain_r   <= cLen;
      havePage_r <= 1'b0;
      changed_r  <= 1'b0;
    end
    else if (ce && state_r == S_LS && acc && !errPl)
    begin
      remain_r <= remain_r - 16'h0001;
      pos_r    <= pos_r + 2'h1;
      if (fld_r != F_PAGE)
        pageLeft_r <= pageLeft_r - 16'h0001;
      case (fld_r)
        F_PAGE:
        begin
          if (pos_r == 2'h0)
            curPage_r <= dataIn[5:0];
          if (pos_r == 2'h2)
            pageLeft_r[15:8] <= dataIn;
          if (pos_r == 2'h3)
          begin
            pageLeft_r[7:0] <= dataIn;
            havePage_r      <= 1'b1;
            lastPage_r      <= curPage_r;
            haveParm_r      <= 1'b0;
            if ({pageLeft_r[15:8], dataIn} != 16'h0000)
              fld_r <= F_PARM;
          end
        end
        F_PARM:
        begin
          if (pos_r == 2'h0)
            curCode_r[15:8] <= dataIn;
          if (pos_r == 2'h1)
            curCode_r[7:0] <= dataIn;
          if (pos_r == 2'h2)
            ctl_r <= dataIn;
          if (pos_r == 2'h3)
          begin
            valLeft_r <= dataIn;
            val_r     <= 32'h0000_0000;
            if (dataIn != 8'h00)
              fld_r <= F_VAL;
          end
        end
        default:
        begin
          valLeft_r <= valLeft_r - 8'h01;
          val_r     <= {val_r[23:0], dataIn};
        end
      endcase
      if (parmEnd)
      begin
        pos_r      <= 2'h0;
        haveParm_r <= 1'b1;
        lastCode_r <= curCode_r;
        changed_r  <= 1'b1;
        fld_r      <= (pageLeft_r == 16'h0001) ? F_PAGE : F_PARM;
      end
    end
  end

  // Parameter update and log action pulses
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      paramWr    <= 1'b0;
      paramPage  <= 6'h00;
      paramCode  <= 16'h0000;
      paramValue <= 32'h0000_0000;
      paramKind  <= PC_CUR_THR;
      paramSaved <= 1'b0;
      logReset   <= 1'b0;
      thrDefault <= 1'b0;
      cumDefault <= 1'b0;
      saveReq    <= 1'b0;
      cmdDone    <= 1'b0;
    end
    else if (ce)
    begin
      paramWr <= state_r == S_LS && acc && parmEnd && !errPl;
      if (state_r == S_LS && acc && parmEnd)
      begin
        paramPage  <= curPage_r;
        paramCode  <= curCode_r;
        paramValue <= (fld_r == F_VAL) ? {val_r[23:0], dataIn} : 32'h0000_0000;
        paramKind  <= pc_r;
        paramSaved <= sp_r && !ctl_r[DS_BIT];
      end
      logReset   <= state_r == S_END && lsOk_r && pcr_r && len_r == 16'h0000;
      thrDefault <= state_r == S_END && lsOk_r && !pcr_r && len_r == 16'h0000
                    && pc_r == PC_DEF_THR;
      cumDefault <= state_r == S_END && lsOk_r && !pcr_r && len_r == 16'h0000
                    && pc_r == PC_DEF_CUM;
      saveReq    <= state_r == S_END && lsOk_r && sp_r;
      cmdDone    <= state_r == S_END;
    end
  end

  // Unit attention toward other initiators
  always_comb
  begin
    uaSet = '0;
    uaClr = '0;
    if (state_r == S_END && lsOk_r && (changed_r || pcr_r || pc_r[1] && len_r == 16'h0000))
      uaSet = ~(NUM_INIT'(1) << initId_r);
    if (regWr && regAddr == REG_UA)
      uaClr = regWdata[NUM_INIT-1:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ua_r <= '0;
    else if (ce)
      ua_r <= (ua_r & ~uaClr) | uaSet;
  end

  // Register writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cdbW0_r   <= 32'h0000_0000;
      cdbW1_r   <= 32'h0000_0000;
      cdbW2_r   <= 16'h0000;
      cfgSave_r <= 1'b0;
      initId_r  <= '0;
    end
    else if (ce && regWr)
    begin
      case (regAddr)
        REG_CDB0: cdbW0_r <= regWdata;
        REG_CDB1: cdbW1_r <= regWdata;
        REG_CDB2: cdbW2_r <= regWdata[15:0];
        REG_CTRL:
        begin
          cfgSave_r <= regWdata[CTRL_SAVE];
          initId_r  <= regWdata[CTRL_ID_LSB +: IDW];
        end
        default: cfgSave_r <= cfgSave_r;
      endcase
    end
  end

  // Register reads, data in the following cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      regRdata <= 32'h0000_0000;
    else if (ce && regRd)
    begin
      case (regAddr)
        REG_CDB0:  regRdata <= cdbW0_r;
        REG_CDB1:  regRdata <= cdbW1_r;
        REG_CDB2:  regRdata <= {16'h0000, cdbW2_r};
        REG_CTRL:  regRdata <= 32'(cfgSave_r) << CTRL_SAVE | 32'(initId_r) << CTRL_ID_LSB;
        REG_STAT:  regRdata <= {16'h0000, status_r, 6'h00, done_r, state_r != S_IDLE};
        REG_SENSE: regRdata <= {16'h0000, asc_r, 4'h0, senseKey_r};
        REG_INFO:  regRdata <= info_r;
        REG_UA:    regRdata <= {ASCQ_LOGCHG, ASC_LOGCHG, SK_UNIT_ATTN, 4'h0, 8'(ua_r)};
        default:   regRdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wl_zero_a: assert property (
    startP && cOpc == OP_WLONG && cLen == 16'h0000 && ce
    |=> state_r == S_END && !medValid ##1 status_r == ST_GOOD)
    else $error("zero count write moved data or failed");

  wl_badlen_a: assert property (
    startP && cOpc == OP_WLONG && cLen != 16'h0000 && cLen != WL_FULL
    |=> status_r == ST_CHECK && senseKey_r == SK_ILLEGAL && asc_r == ASC_CDB)
    else $error("illegal write count not rejected");

  wl_info_a: assert property (
    startP && cOpc == OP_WLONG && cLen != 16'h0000 && cLen != WL_FULL
    |=> info_r == {16'h0000, $past(cLen)} - 32'h0000_020E)
    else $error("information field wrong");

  wl_order_a: assert property (
    medValid && medLast |-> medSec == SEC_ECC && wlCnt_r == WL_FULL[9:0])
    else $error("sector byte order wrong");

  ls_pcrlen_a: assert property (
    startP && cOpc == OP_LSEL && cdbW0_r[8+PCR_BIT] && cLen != 16'h0000
    |=> status_r == ST_CHECK && asc_r == ASC_CDB ##1 !logReset)
    else $error("reset with list length not rejected");

  ls_nosave_a: assert property (
    startP && cOpc == OP_LSEL && cdbW0_r[8+SP_BIT] && !regWdata[CTRL_SAVE]
    |=> status_r == ST_CHECK ##2 !saveReq)
    else $error("save without support not rejected");

  ls_reset_a: assert property (
    startP && cOpc == OP_LSEL && cdbW0_r[8+PCR_BIT] && !cdbW0_r[8+SP_BIT]
    && cLen == 16'h0000 && ce ##1 ce |=> logReset)
    else $error("parameter reset not issued");

  ls_thrdef_a: assert property (
    startP && cOpc == OP_LSEL && !cdbW0_r[8+PCR_BIT] && !cdbW0_r[8+SP_BIT]
    && cdbW0_r[23:22] == PC_DEF_THR && cLen == 16'h0000 && ce ##1 ce
    |=> thrDefault && !cumDefault)
    else $error("default thresholds not restored");

  ua_others_a: assert property (
    ce && uaSet != '0 |=> (ua_r | (NUM_INIT'(1) << initId_r)) == '1)
    else $error("unit attention not raised for others");

  sense_hold_a: assert property (
    state_r == S_IDLE && !startP |=> $stable(asc_r) && $stable(info_r))
    else $error("sense data lost while idle");

  wl_full_c: cover property (state_r == S_WL ##[1:1000] medLast && medValid);
  ls_err_c: cover property (state_r == S_LS && endChk && endAsc == ASC_PLIST);
  ls_parm_c: cover property (paramWr ##[1:50] cmdDone);
  ua_set_c: cover property (uaSet != '0);
endmodule // swlls_engine
`default_nettype wire

/* File: testbench/swlls_host_model.sv */
// Initiator model that offers sector and list bytes
`timescale 1ns/1ps
`default_nettype none
module swlls_host_model
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [9:0] len,
  input  wire logic       dataReady,
  output logic      [7:0] dataIn,
  output logic            dataValid
);
  logic      [7:0] mem [0:1023];
  logic      [9:0] idxR;
  wire logic [9:0] nextIdx = idxR + 10'h001;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dataValid <= 1'b0;
      idxR      <= 10'h000;
      dataIn    <= 8'hA5;
    end
    else if (go)
    begin
      idxR      <= 10'h000;
      dataValid <= (len != 10'h000);
      dataIn    <= mem[0];
    end
    else if (dataValid && dataReady)
    begin
      idxR      <= nextIdx;
      dataValid <= (nextIdx != len);
      dataIn    <= (nextIdx == len) ? ~dataIn : mem[nextIdx];
    end
    else if (!dataValid)
      dataIn <= ~dataIn;
  end
endmodule // swlls_host_model
`default_nettype wire

/* File: testbench/test_scsi_write_long_log_select.sv */
// Testbench for the raw write and log select engine
`timescale 1ns/1ps
`default_nettype none
module test_scsi_write_long_log_select import swlls_pkg::*; ;
  logic        clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, go = 1'b0, medReady = 1'b0;
  logic [7:0]  regAddr = 8'h00, dataIn, medData, uaPending;
  logic [31:0] regWdata = 32'h0, regRdata, medLba, rdv, paramValue;
  logic [9:0]  len = 10'h000;
  logic        dataValid, dataReady, medValid, medLast, cmdDone, paramWr;
  logic        logReset, thrDefault, cumDefault, saveReq, paramSaved;
  logic [1:0]  medSec, paramKind;
  logic [5:0]  paramPage;
  logic [15:0] paramCode;
  logic [3:0]  pulses;
  int          miscompares = 0, tests_run = 0, beats;
  always #2 clk = ~clk;
  always @(posedge clk) medReady <= ~medReady;
  swlls_engine uut (.clk, .rst, .ce(1'b1), .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .dataIn, .dataValid, .dataReady, .medData, .medValid, .medSec, .medLast, .medReady,
    .medLba, .logReset, .thrDefault, .cumDefault, .saveReq, .paramWr, .paramPage,
    .paramCode, .paramValue, .paramKind, .paramSaved, .cmdDone, .uaPending);
  swlls_host_model host (.clk, .rst, .go, .len, .dataReady, .dataIn, .dataValid);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task run(input logic [31:0] c0, c1, c2, input logic [9:0] n, input logic [3:0] id,
           input logic sv, input logic [7:0] st, asc);
    wr(REG_CDB0, c0);
    wr(REG_CDB1, c1);
    wr(REG_CDB2, c2);
    len <= n;
    go <= 1'b1;
    wr(REG_CTRL, {24'h0, id, 2'b00, sv, 1'b1});
    go <= 1'b0;
    pulses = 4'h0;
    beats = 0;
    for (int i = 0; i < 5000 && cmdDone !== 1'b1; i++)
    begin
      @(posedge clk);
      pulses |= {logReset, thrDefault, cumDefault, saveReq};
      if (medValid && medReady)
      begin
        chk(medSec, beats < 512 ? 0 : beats < 514 ? 1 : 2);
        chk(medData, beats % 256);
        chk(medLast, beats == 525);
        beats++;
      end
    end
    chk(cmdDone, 1);
    repeat (2) @(posedge clk) pulses |= {logReset, thrDefault, cumDefault, saveReq};
    rd(REG_STAT);
    chk(rdv[15:8], st);
    if (st == ST_CHECK)
    begin
      rd(REG_SENSE);
      chk({rdv[15:8], rdv[3:0]}, {asc, SK_ILLEGAL});
    end
  endtask
  task lsel(input logic [1:0] fl, pc, input logic [9:0] n, input logic sv,
            input logic [7:0] st, asc);
    run({8'h00, pc, 12'h000, fl, OP_LSEL}, {6'h0, n[9:8], 24'h0}, {24'h0, n[7:0]}, n, 4'h3,
        sv, st, asc);
  endtask
  task lst(input logic [95:0] v);
    for (int i = 0; i < 12; i++) host.mem[i] = v[95 - 8 * i -: 8];
  endtask
  task t_raw;
    for (int i = 0; i < 1024; i++) host.mem[i] = i[7:0];
    run(32'h3412003F, 32'h02007856, 32'h0E, 526, 4'h1, 1'b0, ST_GOOD, 8'h0);
    chk(beats, 526);
    chk(medLba, 32'h12345678);
    run(32'h3412003F, 32'h00007856, 32'h00, 0, 4'h1, 1'b0, ST_GOOD, 8'h0);
    chk(beats, 0);
    run(32'h3412003F, 32'h00007856, 32'h01, 0, 4'h1, 1'b0, ST_CHECK, ASC_CDB);
    rd(REG_INFO);
    chk(rdv, 32'hFFFFFDF3);
    run(32'h3412003F, 32'h02007856, 32'h0F, 0, 4'h1, 1'b0, ST_CHECK, ASC_CDB);
    rd(REG_INFO);
    chk(rdv, 32'h1);
    $display("test raw write done");
  endtask
  task t_ctl;
    wr(REG_UA, 32'hFF);
    lsel(2'b10, 2'b01, 0, 1'b0, ST_GOOD, 8'h0);
    chk(pulses[3], 1);
    chk(uaPending, 8'hF7);
    lsel(2'b10, 2'b01, 8, 1'b0, ST_CHECK, ASC_CDB);
    lsel(2'b01, 2'b01, 0, 1'b0, ST_CHECK, ASC_CDB);
    lsel(2'b01, 2'b01, 0, 1'b1, ST_GOOD, 8'h0);
    chk(pulses[0], 1);
    lsel(2'b00, 2'b10, 0, 1'b0, ST_GOOD, 8'h0);
    chk(pulses[2], 1);
    lsel(2'b00, 2'b11, 0, 1'b0, ST_GOOD, 8'h0);
    chk(pulses[1], 1);
    $display("test log control done");
  endtask
  task t_list;
    lst(96'h02000004_00010000_00000000);
    lsel(2'b00, 2'b01, 8, 1'b0, ST_GOOD, 8'h0);
    chk({paramPage, paramCode}, {6'h02, 16'h0001});
    chk(paramKind, PC_CUR_CUM);
    lsel(2'b00, 2'b01, 6, 1'b0, ST_CHECK, ASC_CDB);
    lsel(2'b00, 2'b01, 0, 1'b0, ST_GOOD, 8'h0);
    rd(REG_SENSE);
    chk(rdv[15:8], ASC_CDB);
    lst(96'h02000005_00014001_AB000000);
    lsel(2'b01, 2'b01, 9, 1'b1, ST_GOOD, 8'h0);
    chk(paramSaved, 0);
    chk(paramValue, 32'hAB);
    lst(96'h01000004_00000000_00000000);
    lsel(2'b00, 2'b01, 8, 1'b0, ST_CHECK, ASC_PLIST);
    lst(96'h02000004_00000000_00000000);
    lsel(2'b00, 2'b01, 8, 1'b0, ST_CHECK, ASC_PLIST);
    lst(96'h06000004_00000000_00000000);
    lsel(2'b00, 2'b00, 8, 1'b0, ST_CHECK, ASC_PLIST);
    lst(96'h03000008_00020000_00010000);
    lsel(2'b00, 2'b01, 12, 1'b0, ST_CHECK, ASC_PLIST);
    rd(8'h3C);
    chk(rdv, 32'h0);
    $display("test log list done");
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_raw;
    t_ctl;
    t_list;
    finish_test;
  end
  initial
  begin
    #40000;
    miscompares++;
    finish_test;
  end
endmodule // test_scsi_write_long_log_select
`default_nettype wire
